// >>> alert_flags_pkg.sv
// Package: register map and field layout of the alert flag bank
`default_nettype none
package alert_flags_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 8;
  localparam int PIN_W = 5;
  // Byte addresses of the word registers
  localparam logic [7:0] ADDR_SOURCE_STATUS = 8'h20;
  localparam logic [7:0] ADDR_ALERT_MASK = 8'h24;
  localparam logic [7:0] ADDR_ADDRESS_CTRL = 8'h28;
  localparam logic [7:0] ADDR_IO_CTRL = 8'h2C;
  // Field positions in the source status word
  localparam int BIT_UNASSIGNED = 7;
  localparam int BIT_CFG_INVALID = 6;
  localparam int BIT_OTP_DOUBLE = 5;
  localparam int BIT_FORCE = 4;
  localparam int BIT_THERMAL = 3;
  localparam int BIT_SLEEP = 2;
  localparam int BIT_OVERTEMP_2 = 1;
  localparam int BIT_OVERTEMP_1 = 0;
  // Field positions in address and I/O control
  localparam int BIT_ADDR_ASSIGNED = 7;
  localparam int BIT_IO_TS1_EN = 0;
  localparam int BIT_IO_TS2_EN = 1;
  localparam int BIT_IO_SLEEP = 2;
  localparam int IO_W = 3;
  // Synchronised pin order
  localparam int PIN_TS1 = 0;
  localparam int PIN_TS2 = 1;
  localparam int PIN_THERMAL = 2;
  localparam int PIN_OTP = 3;
  localparam int PIN_PARITY = 4;
  // Reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [2:0] RST_IO = 3'h0;
  localparam logic RST_UNASSIGNED = 1'b1;
  localparam logic RST_ASSIGNED = 1'b0;
  localparam logic RST_FORCE = 1'b0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  typedef enum logic {ASSIGN_IDLE, ASSIGN_ARMED} assign_clear_e;
endpackage
`default_nettype wire

// >>> pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= pin_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// >>> sticky_flag.sv
// One sticky status bit where a set beats a same-cycle clear
`timescale 1ns/100ps
`default_nettype none
module sticky_flag (
  input wire logic clk,
  input wire logic rstn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  logic q_r;
  logic q_nxt;

  // Set wins so an event in the clear cycle is not lost
  assign q_nxt = set ? 1'b1 : (clr ? 1'b0 : q_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// >>> alert_source_bank.sv
// Alert source status bank with Avalon-MM slave, mask and alert output
//
// What this block does
// - Bit 7 set while address not assigned
// - Unassigned flag clears by 1 then 0
// - Unassigned flag resets to 1, 0 only when assigned
// - Bit 6 flags invalid protected configuration
// - Bit 5 flags uncorrectable OTP error
// - Bit 4 force bit drives alert
// - Bit 3 set while thermal shutdown active
// - Bit 2 set on sleep activation only
// - No repeat sleep alert while held
// - Bit 1 set above second threshold
// - Bit 1 zero when input two disabled
// - Bit 0 set above first threshold
// - Bit 0 zero when input one disabled
// - Flags clear by writing one
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module alert_source_bank
  import alert_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [DATA_W-1:0] writedata,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic ts1_over_pin,
  input wire logic ts2_over_pin,
  input wire logic thermal_shutdown_pin,
  input wire logic otp_double_err_pin,
  input wire logic cfg_parity_bad_pin,
  output logic alert_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic wait_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [FLAG_W-1:0] mask_r;
  logic assigned_r;
  logic [IO_W-1:0] io_r;
  logic force_r;
  logic unassigned_r;
  logic unassigned_nxt;
  logic sleep_prev_r;
  logic alert_r;
  logic irq_r;
  assign_clear_e clr_state_r;
  assign_clear_e clr_state_nxt;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic [FLAG_W-1:0] set_v;
  logic [FLAG_W-1:0] clr_v;
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] status_w;
  logic [7:0] wd;
  wire req = read | write;
  wire commit = req & ~wait_r;
  wire wr_lane0 = write & commit & byteenable[0];
  wire sel_status = (address == ADDR_SOURCE_STATUS);
  wire sel_mask = (address == ADDR_ALERT_MASK);
  wire sel_addr = (address == ADDR_ADDRESS_CTRL);
  wire sel_io = (address == ADDR_IO_CTRL);
  wire wr_status = wr_lane0 & sel_status;
  wire en1 = io_r[BIT_IO_TS1_EN];
  wire en2 = io_r[BIT_IO_TS2_EN];
  wire sleep_req = io_r[BIT_IO_SLEEP];
  wire sleep_rise = sleep_req & ~sleep_prev_r;
  wire arm_ok = wr_status & wd[BIT_UNASSIGNED] & assigned_r;
  wire clear_ok = wr_status & ~wd[BIT_UNASSIGNED] & assigned_r;

  assign wd = writedata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, comparators come from the analog side

  assign pin_raw[PIN_TS1] = ts1_over_pin;
  assign pin_raw[PIN_TS2] = ts2_over_pin;
  assign pin_raw[PIN_THERMAL] = thermal_shutdown_pin;
  assign pin_raw[PIN_OTP] = otp_double_err_pin;
  assign pin_raw[PIN_PARITY] = cfg_parity_bad_pin;

  pin_sync #(.WIDTH(PIN_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in(pin_raw),
    .sync_out(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags

  assign set_v[BIT_UNASSIGNED] = 1'b0;
  assign set_v[BIT_CFG_INVALID] = pin_s[PIN_PARITY];
  assign set_v[BIT_OTP_DOUBLE] = pin_s[PIN_OTP];
  assign set_v[BIT_FORCE] = 1'b0;
  assign set_v[BIT_THERMAL] = pin_s[PIN_THERMAL];
  // Edge of the request, so a held sleep request cannot re-alert
  assign set_v[BIT_SLEEP] = sleep_rise;
  assign set_v[BIT_OVERTEMP_2] = pin_s[PIN_TS2] & en2;
  assign set_v[BIT_OVERTEMP_1] = pin_s[PIN_TS1] & en1;

  // Write-one-to-clear; a disabled input also drops its flag
  assign clr_v = ({FLAG_W{wr_status}} & wd)
               | {6'h00, ~en2, ~en1};

  genvar i;
  generate
    for (i = 0; i < FLAG_W; i++) begin : g_flag
      if (i != BIT_UNASSIGNED && i != BIT_FORCE) begin : g_cell
        sticky_flag u_flag (
          .clk(clk),
          .rstn(rstn),
          .set(set_v[i]),
          .clr(clr_v[i]),
          .q(flag_q[i])
        );
      end else begin : g_none
        assign flag_q[i] = 1'b0;
      end
    end
  endgenerate

  assign status_w[BIT_UNASSIGNED] = unassigned_r;
  assign status_w[BIT_CFG_INVALID] = flag_q[BIT_CFG_INVALID];
  assign status_w[BIT_OTP_DOUBLE] = flag_q[BIT_OTP_DOUBLE];
  assign status_w[BIT_FORCE] = force_r;
  assign status_w[BIT_THERMAL] = flag_q[BIT_THERMAL];
  assign status_w[BIT_SLEEP] = flag_q[BIT_SLEEP];
  assign status_w[BIT_OVERTEMP_2] = flag_q[BIT_OVERTEMP_2] & en2;
  assign status_w[BIT_OVERTEMP_1] = flag_q[BIT_OVERTEMP_1] & en1;

  ////////////////////////////////////////////////////////////////////////
  // Address-unassigned flag: one write of 1 arms, a later 0 clears

  always_comb begin
    clr_state_nxt = clr_state_r;
    unassigned_nxt = unassigned_r;
    unique case (clr_state_r)
      ASSIGN_IDLE: begin
        if (arm_ok) begin
          clr_state_nxt = ASSIGN_ARMED;
        end
      end
      ASSIGN_ARMED: begin
        if (!assigned_r) begin
          clr_state_nxt = ASSIGN_IDLE;
        end else if (clear_ok) begin
          clr_state_nxt = ASSIGN_IDLE;
          unassigned_nxt = 1'b0;
        end
      end
    endcase
    // Losing the address wins over the clearing write
    if (!assigned_r) begin
      unassigned_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clr_state_r <= ASSIGN_IDLE;
      unassigned_r <= RST_UNASSIGNED;
    end else begin
      clr_state_r <= clr_state_nxt;
      unassigned_r <= unassigned_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers written by software

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= RST_MASK;
      assigned_r <= RST_ASSIGNED;
      io_r <= RST_IO;
      force_r <= RST_FORCE;
    end else if (wr_lane0) begin
      if (sel_mask) mask_r <= wd;
      if (sel_addr) assigned_r <= wd[BIT_ADDR_ASSIGNED];
      if (sel_io) io_r <= wd[IO_W-1:0];
      if (sel_status) force_r <= wd[BIT_FORCE];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_prev_r <= 1'b0;
    end else begin
      sleep_prev_r <= sleep_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: fixed one wait state, unmapped reads return zero

  assign rdata_nxt = sel_status ? {24'h00_0000, status_w} :
                     sel_mask ? {24'h00_0000, mask_r} :
                     sel_addr ? {24'h00_0000, assigned_r, 7'h00} :
                     sel_io ? {29'h0000_0000, io_r} :
                     32'h0000_0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_r <= 1'b1;
      rdata_r <= RST_RDATA;
    end else begin
      wait_r <= ~(req & wait_r);
      if (read & wait_r) rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alert and interrupt outputs

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alert_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      alert_r <= |status_w;
      irq_r <= |(status_w & mask_r);
    end
  end

  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign alert_out = alert_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_arm;
    arm_ok;
  endsequence

  sequence s_clear_write;
    clear_ok && clr_state_r == ASSIGN_ARMED;
  endsequence

  sequence s_force_write;
    wr_status;
  endsequence

  unassigned_follow_a: assert property (
    !assigned_r |=> unassigned_r && status_w[BIT_UNASSIGNED])
    else $error("unassigned flag not set while address missing");

  // Two idle cycles: the host model commits successive writes three edges apart
  unassigned_two_step_a: assert property (
    s_arm ##1 (!wr_status && assigned_r)[*2] ##1 s_clear_write
    |=> !unassigned_r)
    else $error("unassigned flag not cleared by 1 then 0");

  unassigned_fall_a: assert property (
    $fell(unassigned_r) |-> $past(clear_ok) && $past(assigned_r))
    else $error("unassigned flag cleared without assignment");

  cfg_invalid_set_a: assert property (
    pin_s[PIN_PARITY] |=> status_w[BIT_CFG_INVALID] ##1 alert_r)
    else $error("configuration invalid flag missed");

  otp_double_set_a: assert property (
    pin_s[PIN_OTP] |=> status_w[BIT_OTP_DOUBLE])
    else $error("uncorrectable otp flag missed");

  force_alert_a: assert property (
    s_force_write |=> force_r == $past(wd[BIT_FORCE])
    ##1 (!force_r || alert_r))
    else $error("force bit did not drive alert");

  thermal_set_a: assert property (
    pin_s[PIN_THERMAL] |=> status_w[BIT_THERMAL])
    else $error("thermal shutdown flag missed");

  sleep_edge_a: assert property (
    $rose(flag_q[BIT_SLEEP]) |-> $past(sleep_rise))
    else $error("sleep flag set without activation");

  sleep_held_a: assert property (
    (!flag_q[BIT_SLEEP] && sleep_req && sleep_prev_r) |=>
    !flag_q[BIT_SLEEP])
    else $error("sleep flag reappeared while held");

  overtemp_two_a: assert property (
    pin_s[PIN_TS2] && en2 && !(wr_lane0 && sel_io) |=>
    status_w[BIT_OVERTEMP_2])
    else $error("second overtemperature flag missed");

  overtemp_two_off_a: assert property (
    !en2 |-> !status_w[BIT_OVERTEMP_2] ##1 !flag_q[BIT_OVERTEMP_2])
    else $error("second overtemperature flag while disabled");

  overtemp_one_a: assert property (
    pin_s[PIN_TS1] && en1 && !(wr_lane0 && sel_io) |=>
    status_w[BIT_OVERTEMP_1])
    else $error("first overtemperature flag missed");

  overtemp_one_off_a: assert property (
    !en1 |-> !status_w[BIT_OVERTEMP_1] ##1 !flag_q[BIT_OVERTEMP_1])
    else $error("first overtemperature flag while disabled");

  flag_clear_a: assert property (
    $fell(flag_q[BIT_OTP_DOUBLE]) |->
    $past(wr_status) && $past(wd[BIT_OTP_DOUBLE]))
    else $error("otp flag cleared without write of one");

  alert_level_a: assert property (
    (status_w == 8'h00) [*2] |-> !alert_r)
    else $error("alert active with all flags clear");

  bus_answer_a: assert property (
    (req && wait_r) |-> ##1 !wait_r ##1 wait_r)
    else $error("bus answer not in one wait state");

  irq_level_a: assert property (
    (|(status_w & mask_r)) |=> irq_r)
    else $error("interrupt missing for unmasked flag");

  mask_write_a: assert property (
    (wr_lane0 && sel_mask) |=> mask_r == $past(wd))
    else $error("mask write did not land");

  force_hold_a: assert property (
    !wr_status |=> $stable(force_r))
    else $error("force bit changed without status write");

endmodule
`default_nettype wire

// >>> host_model.sv
// Avalon-MM host model that reads and clears the alert flag bank
`timescale 1ns/100ps
`default_nettype none
module host_model
  import alert_flags_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [DATA_W-1:0] writedata,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////////////////
  // Request stays put until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= w ? d : ~d;
    @(posedge clk);
    // No cycle limit here; only the bench watchdog ends a hung wait
    while (waitrequest) begin
      @(posedge clk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Idle data toggles so a stale value is never mistaken for a write
    writedata <= ~d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> alert_source_bank_test.sv
// Self-checking bench for the alert source status bank
`timescale 1ns/100ps
`default_nettype none
module alert_source_bank_test
  import alert_flags_pkg::*;
;
  typedef struct packed {
    logic [4:0] pins;
    logic [2:0] io;
    logic [7:0] st;
  } row_s;
  logic clk;
  logic rstn;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [DATA_W-1:0] writedata;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic [PIN_W-1:0] pins;
  logic alert_out;
  logic irq;
  logic [31:0] q;
  int error_cnt = 0;
  int n_compared = 0;
  // Pins: bit0 ts1, bit1 ts2, bit2 thermal, bit3 otp, bit4 parity
  row_s rows [8] = '{'{5'h01, 3'h1, 8'h81}, '{5'h01, 3'h0, 8'h80},
    '{5'h02, 3'h2, 8'h82}, '{5'h02, 3'h0, 8'h80},
    '{5'h04, 3'h0, 8'h88}, '{5'h08, 3'h0, 8'hA0},
    '{5'h10, 3'h0, 8'hC0}, '{5'h00, 3'h4, 8'h84}};
  //////////////////////////////////////////////////////////////////////////
  alert_source_bank i_dut (
    .clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .ts1_over_pin(pins[PIN_TS1]), .ts2_over_pin(pins[PIN_TS2]),
    .thermal_shutdown_pin(pins[PIN_THERMAL]),
    .otp_double_err_pin(pins[PIN_OTP]),
    .cfg_parity_bad_pin(pins[PIN_PARITY]),
    .alert_out(alert_out), .irq(irq)
  );
  host_model i_host (
    .clk(clk), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    pins = 5'h00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_IO_CTRL, {29'h0, rows[i].io});
      pins <= rows[i].pins;
      repeat (6) @(posedge clk);
      rd_chk(ADDR_SOURCE_STATUS, {24'h0, rows[i].st});
      chk({31'h0, alert_out}, 32'h1);
      pins <= 5'h00;
      repeat (4) @(posedge clk);
      wr(ADDR_IO_CTRL, 32'h0);
      wr(ADDR_SOURCE_STATUS, 32'h6F);
      rd_chk(ADDR_SOURCE_STATUS, 32'h80);
    end
    // Sleep request still held after its flag is cleared
    wr(ADDR_IO_CTRL, 32'h04);
    wr(ADDR_SOURCE_STATUS, 32'h04);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_SOURCE_STATUS, 32'h80);
    wr(ADDR_IO_CTRL, 32'h00);
    // Unassigned flag: a lone zero does nothing, then 1 and 0
    wr(ADDR_SOURCE_STATUS, 32'h00);
    rd_chk(ADDR_SOURCE_STATUS, 32'h80);
    wr(ADDR_ADDRESS_CTRL, 32'h80);
    rd_chk(ADDR_SOURCE_STATUS, 32'h80);
    wr(ADDR_SOURCE_STATUS, 32'h80);
    wr(ADDR_SOURCE_STATUS, 32'h00);
    rd_chk(ADDR_SOURCE_STATUS, 32'h00);
    chk({31'h0, alert_out}, 32'h0);
    // Force bit drives the alert alone
    wr(ADDR_SOURCE_STATUS, 32'h10);
    @(posedge clk);
    chk({31'h0, alert_out}, 32'h1);
    rd_chk(ADDR_SOURCE_STATUS, 32'h10);
    wr(ADDR_SOURCE_STATUS, 32'h00);
    @(posedge clk);
    chk({31'h0, alert_out}, 32'h0);
    // Interrupt raised, masked and cleared
    wr(ADDR_ALERT_MASK, 32'h01);
    wr(ADDR_IO_CTRL, 32'h01);
    pins <= 5'h01;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_ALERT_MASK, 32'h00);
    pins <= 5'h00;
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_ALERT_MASK, 32'h01);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_SOURCE_STATUS, 32'h01);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h30, 32'h0);
    wr(ADDR_ADDRESS_CTRL, 32'h00);
    rd_chk(ADDR_SOURCE_STATUS, 32'h80);
    // Reset in mid-run restores defaults
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(ADDR_SOURCE_STATUS, 32'h80);
    rd_chk(ADDR_ALERT_MASK, 32'h0);
    rd_chk(ADDR_IO_CTRL, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
